// [rtl/sxc_ctrl_status.sv]
// System handler priorities, handler control and state, and configurable fault status registers.
// Operation
// - Priority registers take byte, aligned halfword and word reads and writes.
// - Second priority register holds supervisor call priority in its top byte.
// - Third register holds tick, pendable service and monitor priorities; byte 1 reserved.
// - Core updates state bits; software writes may also set or clear pending and active.
// - Clearing an active bit recomputes execution priority from the remaining active bits.
// - Bits 18, 17, 16 enable usage, bus and memory faults.
// - Bits 15 to 12 show supervisor call, bus, memory and usage pending.
// - Pending sets when the exception occurs and clears when it becomes active.
// - Active bits sit at 11, 10, 8, 7, 3, 1 and 0.
// - Active reads one while current or nested under a preempting exception.
// - Fault status word: usage in 31:16, bus in 15:8, memory in 7:0.
// - Fault status word is reachable by word, halfword and byte accesses.
// - Writing one clears a fault status bit; writing zero leaves it.
// - Fault status bits accumulate until software clears them.
// - Memory fault status byte is byte accessible, lowest byte of the word.
// - Memory status bit 7 marks a valid captured fault address.
// - Memory status bit 5 sets on a fault during lazy floating-point preservation.
// - Bit 4 marks stacking faults, bit 3 unstacking faults.
// - Bit 1 marks a data access violation; its address is captured when bit 7 is also set.
// - Bit 0 marks an issued instruction-fetch or execute-never violation.
`include "sxc_cfg.svh"

module sxc_ctrl_status
  import sxc_pkg::*;
(
  input  wire logic                   i_clock,
  input  wire logic                   i_reset,
  input  wire logic [`SXC_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic [3:0]             i_byte_en,
  input  wire logic                   i_write,
  input  wire logic                   i_read,
  output logic      [31:0]            o_rdata,
  input  wire logic [6:0]             i_pend_set,
  input  wire logic [6:0]             i_act_set,
  input  wire logic [6:0]             i_act_clr,
  input  wire logic [15:0]            i_usage_fault,
  input  wire logic [7:0]             i_bus_fault,
  input  wire logic [7:0]             i_mem_fault,
  input  wire logic [31:0]            i_mem_fault_addr,
  input  wire logic [31:0]            i_bus_fault_addr,
  output logic      [7:0]             o_exec_prio,
  output logic                        o_exec_prio_valid,
  output logic      [2:0]             o_fault_enable,
  output logic      [6:0]             o_pending,
  output logic      [6:0]             o_active
);

  sxc_bus_req_t  req;
  sxc_core_evt_t evt;

  logic [31:0] prio2_ff;
  logic [31:0] prio3_ff;
  logic [31:0] csr_ff;
  logic [31:0] fsr_ff;
  logic [31:0] mm_addr_ff;
  logic [31:0] bf_addr_ff;
  logic [31:0] rdata_ff;
  logic [7:0]  exec_prio_ff;
  logic        exec_valid_ff;

  logic [31:0] nxt_prio2;
  logic [31:0] nxt_prio3;
  logic [31:0] nxt_csr;
  logic [31:0] nxt_fsr;
  logic [31:0] nxt_rdata;

  // Expands byte enables into a bit mask for partial accesses.
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Merges written lanes into an old value, touching only implemented bits.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] lanes, input logic [31:0] impl);
    logic [31:0] m;
    m = lanes & impl;
    merge = (old & ~m) | (wd & m);
  endfunction

  // Maps exception slots to their control and state bit positions.
  function automatic logic [31:0] act_to_csr(input logic [6:0] v);
    act_to_csr = {20'h00000, v[SXC_EXC_TICK], v[SXC_EXC_PSV], 1'b0, v[SXC_EXC_MON], v[SXC_EXC_SVC],
                  3'h0, v[SXC_EXC_USAGE], 1'b0, v[SXC_EXC_BUS], v[SXC_EXC_MEM]};
  endfunction

  function automatic logic [31:0] pend_to_csr(input logic [6:0] v);
    pend_to_csr = {16'h0000, v[SXC_EXC_SVC], v[SXC_EXC_BUS], v[SXC_EXC_MEM], v[SXC_EXC_USAGE], 12'h000};
  endfunction

  function automatic logic [6:0] csr_to_act(input logic [31:0] c);
    csr_to_act = {c[11], c[10], c[8], c[7], c[3], c[1], c[0]};
  endfunction

  function automatic logic [6:0] csr_to_pend(input logic [31:0] c);
    csr_to_pend = {3'h0, c[15], c[12], c[14], c[13]};
  endfunction

  assign req = '{addr: i_addr, wdata: i_wdata, byte_en: i_byte_en, write: i_write, read: i_read};
  assign evt = '{pend_set: i_pend_set, act_set: i_act_set, act_clr: i_act_clr, usage_fault: i_usage_fault,
                 bus_fault: i_bus_fault, mem_fault: i_mem_fault, mem_fault_addr: i_mem_fault_addr,
                 bus_fault_addr: i_bus_fault_addr};

  wire logic [31:0] lanes = lane_mask(req.byte_en);
  wire logic        wr_prio2 = req.write && (req.addr == `SXC_OFF_PRIO_8_11);
  wire logic        wr_prio3 = req.write && (req.addr == `SXC_OFF_PRIO_12_15);
  wire logic        wr_csr   = req.write && (req.addr == `SXC_OFF_CTRL_STATE);
  wire logic        wr_fsr   = req.write && (req.addr == `SXC_OFF_FAULT_STAT);

  wire logic [31:0] fsr_mask = {`SXC_UFSR_MASK, `SXC_BFSR_MASK, `SXC_MEMORY_FAULT_STATUS_MASK};

  // Priority writes keep only the implemented handler bytes.
  assign nxt_prio2 = wr_prio2 ? merge(prio2_ff, req.wdata, lanes, `SXC_PRIO2_MASK) : prio2_ff;
  assign nxt_prio3 = wr_prio3 ? merge(prio3_ff, req.wdata, lanes, `SXC_PRIO3_MASK) : prio3_ff;

  // Software write first, then the core's pending and active events on top of it.
  wire logic [31:0] csr_sw = wr_csr ? merge(csr_ff, req.wdata, lanes, `SXC_CSR_MASK) : csr_ff;
  wire logic [31:0] pend_from_core = pend_to_csr(evt.pend_set);
  wire logic [31:0] pend_taken = pend_to_csr(evt.act_set);
  wire logic [31:0] act_set_w = act_to_csr(evt.act_set);
  wire logic [31:0] act_clr_w = act_to_csr(evt.act_clr);

  // Exception occurrence wins over a same-cycle clear; activation retires the pending bit.
  assign nxt_csr = (((csr_sw & ~pend_taken) | pend_from_core) & ~act_clr_w | act_set_w) & `SXC_CSR_MASK;

  // Write-one-to-clear with new faults winning over the clear.
  wire logic [31:0] new_faults = {evt.usage_fault, evt.bus_fault, evt.mem_fault} & fsr_mask;
  wire logic [31:0] fsr_clr    = wr_fsr ? (req.wdata & lanes) : 32'h00000000;
  assign nxt_fsr = ((fsr_ff & ~fsr_clr) | new_faults) & fsr_mask;

  // Address is captured with its valid flag on a data access violation.
  wire logic mm_capture = evt.mem_fault[`SXC_MM_DATA_VIOL] && evt.mem_fault[`SXC_MM_ADDR_VALID];
  wire logic bf_capture = evt.bus_fault[`SXC_BF_PRECISE] && evt.bus_fault[`SXC_BF_ADDR_VALID];

  // Execution priority is the numerically lowest priority among active handlers.
  logic [6:0]  act_vec;
  logic [7:0]  prio_of [7];
  logic [7:0]  best_prio;
  logic        any_act;
  assign act_vec = csr_to_act(nxt_csr);
  assign prio_of[SXC_EXC_MEM]   = 8'h00;
  assign prio_of[SXC_EXC_BUS]   = 8'h00;
  assign prio_of[SXC_EXC_USAGE] = 8'h00;
  assign prio_of[SXC_EXC_SVC]   = nxt_prio2[31:24];
  assign prio_of[SXC_EXC_MON]   = nxt_prio3[7:0];
  assign prio_of[SXC_EXC_PSV]   = nxt_prio3[23:16];
  assign prio_of[SXC_EXC_TICK]  = nxt_prio3[31:24];

  always_comb begin
    best_prio = 8'hFF;
    any_act   = 1'b0;
    for (int k = 0; k < 7; k++) begin
      if (act_vec[k] && (!any_act || prio_of[k] < best_prio)) begin
        best_prio = prio_of[k];
        any_act   = 1'b1;
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    case (req.addr)
      `SXC_OFF_PRIO_8_11:  nxt_rdata = prio2_ff;
      `SXC_OFF_PRIO_12_15: nxt_rdata = prio3_ff;
      `SXC_OFF_CTRL_STATE: nxt_rdata = csr_ff;
      `SXC_OFF_FAULT_STAT: nxt_rdata = fsr_ff;
      `SXC_OFF_FAULT_ADDR: nxt_rdata = mm_addr_ff;
      default:             nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      prio2_ff <= `SXC_RESET_WORD;
      prio3_ff <= `SXC_RESET_WORD;
      csr_ff   <= `SXC_RESET_WORD;
      fsr_ff   <= `SXC_RESET_WORD;
    end else begin
      prio2_ff <= nxt_prio2;
      prio3_ff <= nxt_prio3;
      csr_ff   <= nxt_csr;
      fsr_ff   <= nxt_fsr;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mm_addr_ff <= `SXC_RESET_WORD;
      bf_addr_ff <= `SXC_RESET_WORD;
    end else begin
      if (mm_capture) begin
        mm_addr_ff <= evt.mem_fault_addr;
      end
      if (bf_capture) begin
        bf_addr_ff <= evt.bus_fault_addr;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rdata_ff      <= `SXC_RESET_WORD;
      exec_prio_ff  <= 8'hFF;
      exec_valid_ff <= 1'b0;
    end else begin
      rdata_ff      <= req.read ? (nxt_rdata & lanes) : 32'h00000000;
      exec_prio_ff  <= best_prio;
      exec_valid_ff <= any_act;
    end
  end

  logic [2:0] en_ff;
  logic [6:0] pend_ff;
  logic [6:0] act_ff;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      en_ff   <= 3'h0;
      pend_ff <= 7'h00;
      act_ff  <= 7'h00;
    end else begin
      en_ff   <= nxt_csr[18:16];
      pend_ff <= csr_to_pend(nxt_csr);
      act_ff  <= act_vec;
    end
  end

  assign o_rdata           = rdata_ff;
  assign o_exec_prio       = exec_prio_ff;
  assign o_exec_prio_valid = exec_valid_ff;
  assign o_fault_enable    = en_ff;
  assign o_pending         = pend_ff;
  assign o_active          = act_ff;

endmodule

// [rtl/sxc_cfg.svh]
// Register offsets, field positions and reset values of the system exception control and status block.
`ifndef SXC_CFG_SVH
`define SXC_CFG_SVH
`define SXC_ADDR_W        8
`define SXC_OFF_PRIO_8_11  8'h00
`define SXC_OFF_PRIO_12_15 8'h04
`define SXC_OFF_CTRL_STATE 8'h08
`define SXC_OFF_FAULT_STAT 8'h0C
`define SXC_OFF_FAULT_ADDR 8'h10
`define SXC_PRIO2_MASK     32'hFF000000
`define SXC_PRIO3_MASK     32'hFFFF00FF
`define SXC_CSR_MASK       32'h0007FD8B
`define SXC_UFSR_MASK      16'h030F
`define SXC_BFSR_MASK      8'hBF
`define SXC_MEMORY_FAULT_STATUS_MASK     8'hBB
`define SXC_MM_ADDR_VALID  7
`define SXC_MM_LAZY_FP     5
`define SXC_MM_STACKING    4
`define SXC_MM_UNSTACKING  3
`define SXC_MM_DATA_VIOL   1
`define SXC_MM_INSTR_VIOL  0
`define SXC_BF_ADDR_VALID  7
`define SXC_BF_PRECISE     1
`define SXC_RESET_WORD     32'h00000000
`endif

// [rtl/sxc_pkg.sv]
// Types shared by the system exception control and status block.
package sxc_pkg;
  // One exception-state slot per handled system exception.
  typedef enum logic [2:0] {
    SXC_EXC_MEM   = 3'h0,
    SXC_EXC_BUS   = 3'h1,
    SXC_EXC_USAGE = 3'h2,
    SXC_EXC_SVC   = 3'h3,
    SXC_EXC_MON   = 3'h4,
    SXC_EXC_PSV   = 3'h5,
    SXC_EXC_TICK  = 3'h6
  } sxc_exc_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  byte_en;
    logic        write;
    logic        read;
  } sxc_bus_req_t;

  typedef struct packed {
    logic [6:0]  pend_set;
    logic [6:0]  act_set;
    logic [6:0]  act_clr;
    logic [15:0] usage_fault;
    logic [7:0]  bus_fault;
    logic [7:0]  mem_fault;
    logic [31:0] mem_fault_addr;
    logic [31:0] bus_fault_addr;
  } sxc_core_evt_t;
endpackage

// [tb/sxc_ctrl_status_assertions.sv]
// Port-level checks of the system exception control and status block.
`include "sxc_cfg.svh"
module sxc_chk
  import sxc_pkg::*;
(
  input wire logic                   i_clock,
  input wire logic                   i_reset,
  input wire logic [`SXC_ADDR_W-1:0] i_addr,
  input wire logic [31:0]            i_wdata,
  input wire logic [3:0]             i_byte_en,
  input wire logic                   i_write,
  input wire logic                   i_read,
  input wire logic [31:0]            o_rdata,
  input wire logic [6:0]             i_pend_set,
  input wire logic [6:0]             i_act_set,
  input wire logic [6:0]             i_act_clr,
  input wire logic [7:0]             i_mem_fault,
  input wire logic [7:0]             o_exec_prio,
  input wire logic                   o_exec_prio_valid,
  input wire logic [2:0]             o_fault_enable,
  input wire logic [6:0]             o_pending,
  input wire logic [6:0]             o_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  pend_set_a: assert property (i_pend_set[3] && !i_act_set[3] |=> o_pending[3])
    else $error("pending bit not set");
  act_entry_a: assert property (i_act_set[3] && !i_pend_set[3] && !i_write |=> o_active[3] && !o_pending[3])
    else $error("entry did not swap pending for active");
  act_return_a: assert property (i_act_clr[6] && !i_act_set[6] && !i_write |=> !o_active[6])
    else $error("active kept after return");
  act_nested_a: assert property (o_active[3] && !i_act_clr[3] && !i_write |=> o_active[3])
    else $error("nested active lost");
  fault_prio_a: assert property (|o_active[2:0] |-> o_exec_prio == 8'h00)
    else $error("fault active but priority not zero");
  prio_valid_a: assert property (o_exec_prio_valid == (|o_active))
    else $error("priority valid disagrees with active");
  enable_write_a: assert property (i_write && i_addr == 8'h08 && i_byte_en[2] |=> o_fault_enable == $past(i_wdata[18:16]))
    else $error("fault enables not written");
  data_viol_a: assert property (i_mem_fault[1] ##1 !i_write ##1 i_read && i_addr == 8'h0C && i_byte_en[0] |=> o_rdata[1])
    else $error("data violation not kept");
  prio_reserved_a: assert property (i_read && i_addr == 8'h00 |=> o_rdata[23:0] == 24'h000000)
    else $error("reserved priority bytes not zero");
  cover property (i_act_set[6] && o_active[3]);
  cover property (i_read && i_addr == 8'h0C);
  cover property (i_write && i_addr == 8'h08);
endmodule

bind sxc_ctrl_status sxc_chk sxc_chk_inst (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_byte_en(i_byte_en), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
  .i_pend_set(i_pend_set), .i_act_set(i_act_set), .i_act_clr(i_act_clr), .i_mem_fault(i_mem_fault),
  .o_exec_prio(o_exec_prio), .o_exec_prio_valid(o_exec_prio_valid), .o_fault_enable(o_fault_enable),
  .o_pending(o_pending), .o_active(o_active));

// [tb/sxc_core_model.sv]
// Behavioural model of the core's exception entry, return and fault reporting.
module sxc_core_model
  import sxc_pkg::*;
(
  input  wire logic    i_clock,
  output sxc_core_evt_t o_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_evt = '0;
  // Events last one cycle; a released fault address turns to its inverse so a late capture shows.
  task automatic pulse(input sxc_core_evt_t e);
    @(posedge i_clock);
    o_evt <= e;
    @(posedge i_clock);
    o_evt <= '{mem_fault_addr: ~e.mem_fault_addr, bus_fault_addr: ~e.bus_fault_addr, default: '0};
  endtask
  // Kind bit 0 raises pending, bit 1 enters the handler, bit 2 returns from it.
  task automatic exc(input logic [2:0] k, input sxc_exc_t s);
    sxc_core_evt_t e;
    e = '0;
    e.pend_set[s] = k[0];
    e.act_set[s] = k[1];
    e.act_clr[s] = k[2];
    pulse(e);
  endtask
  task automatic fault(input logic [15:0] u, input logic [7:0] b, input logic [7:0] m, input logic [31:0] a);
    pulse('{7'h00, 7'h00, 7'h00, u, b, m, a, a});
  endtask
endmodule

// [tb/system_exception_ctrl_status_tb.sv]
// Register-level testbench of the system exception control and status block.
module system_exception_ctrl_status_tb;
  import sxc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic          i_clock;
  logic          i_reset;
  sxc_bus_req_t  req;
  sxc_core_evt_t evt;
  logic [31:0]   o_rdata;
  logic [7:0]    o_exec_prio;
  logic          o_exec_prio_valid;
  logic [2:0]    o_fault_enable;
  logic [6:0]    o_pending;
  logic [6:0]    o_active;
  int            errors;
  int            checks_done;

  sxc_ctrl_status sxc_ctrl_status_inst (.i_clock(i_clock), .i_reset(i_reset), .i_addr(req.addr),
    .i_wdata(req.wdata), .i_byte_en(req.byte_en), .i_write(req.write), .i_read(req.read),
    .o_rdata(o_rdata), .i_pend_set(evt.pend_set), .i_act_set(evt.act_set), .i_act_clr(evt.act_clr),
    .i_usage_fault(evt.usage_fault), .i_bus_fault(evt.bus_fault), .i_mem_fault(evt.mem_fault),
    .i_mem_fault_addr(evt.mem_fault_addr), .i_bus_fault_addr(evt.bus_fault_addr),
    .o_exec_prio(o_exec_prio), .o_exec_prio_valid(o_exec_prio_valid), .o_fault_enable(o_fault_enable),
    .o_pending(o_pending), .o_active(o_active));
  sxc_core_model sxc_core_model_inst (.i_clock(i_clock), .o_evt(evt));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge i_clock);
    req <= '{a, d, be, 1'b1, 1'b0};
    @(posedge i_clock);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] e, input string n);
    @(posedge i_clock);
    req <= '{a, 32'h00000000, be, 1'b0, 1'b1};
    @(posedge i_clock);
    req <= '0;
    #1;
    chk(n, e, o_rdata);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  initial begin
    #50us;
    errors++;
    report_and_stop();
  end
  initial begin
    req = '0;
    i_reset = 1'b1;
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int a = 0; a <= 32; a += 4) rd(a[7:0], 4'hF, 32'h00000000, "reset");
    wr(8'h00, 4'hF, 32'hFFFFFFFF);
    rd(8'h00, 4'hF, 32'hFF000000, "prio_8_11");
    wr(8'h04, 4'hF, 32'hFFFFFFFF);
    wr(8'h04, 4'hC, 32'h12340000);
    rd(8'h04, 4'hF, 32'h123400FF, "prio_12_15");
    rd(8'h04, 4'h1, 32'h000000FF, "prio_byte");
    wr(8'h20, 4'hF, 32'hFFFFFFFF);
    rd(8'h20, 4'hF, 32'h00000000, "unmapped");
    wr(8'h08, 4'hF, 32'hFFFFFFFF);
    rd(8'h08, 4'hF, 32'h0007FD8B, "ctrl_state");
    chk("enable", 32'h7, {29'h0, o_fault_enable});
    chk("pending", 32'hF, {25'h0, o_pending});
    wr(8'h08, 4'hF, 32'h00000000);
    chk("idle_prio", 32'hFF, {24'h0, o_exec_prio});
    sxc_core_model_inst.exc(3'h1, SXC_EXC_SVC);
    rd(8'h08, 4'hF, 32'h00008000, "svc_pend");
    sxc_core_model_inst.exc(3'h2, SXC_EXC_SVC);
    rd(8'h08, 4'hF, 32'h00000080, "svc_act");
    wr(8'h08, 4'hF, o_rdata | 32'h00010000);
    sxc_core_model_inst.exc(3'h2, SXC_EXC_TICK);
    rd(8'h08, 4'hF, 32'h00010880, "nested");
    chk("exec_prio", 32'h12, {24'h0, o_exec_prio});
    sxc_core_model_inst.exc(3'h4, SXC_EXC_TICK);
    rd(8'h08, 4'hF, 32'h00010080, "tick_ret");
    wr(8'h08, 4'h1, 32'h00000000);
    chk("prio_valid", 32'h0, {31'h0, o_exec_prio_valid});
    chk("mem_enable", 32'h1, {29'h0, o_fault_enable});
    sxc_core_model_inst.fault(16'hFFFF, 8'hFF, 8'hFF, 32'h20000040);
    rd(8'h0C, 4'hF, 32'h030FBFBB, "fault_word");
    rd(8'h0C, 4'h1, 32'h000000BB, "mem_byte");
    rd(8'h10, 4'hF, 32'h20000040, "fault_addr");
    wr(8'h0C, 4'h1, 32'h00000002);
    rd(8'h0C, 4'hF, 32'h030FBFB9, "w1c");
    wr(8'h0C, 4'hF, 32'hFFFFFFFF);
    sxc_core_model_inst.fault(16'h0000, 8'h00, 8'h01, 32'h00000000);
    sxc_core_model_inst.fault(16'h0000, 8'h00, 8'h08, 32'h00000000);
    rd(8'h0C, 4'h3, 32'h00000009, "accumulate");
    report_and_stop();
  end
endmodule
